// ### logic/tcc_timer.sv
// tcc_timer: two-channel capture/compare/pwm timer with byte register port
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer (
   // clock and reset
   input  wire  logic                          core_clk_i,
   input  wire  logic                          rst_b_i,
   // register port
   input  wire  logic [tcc_pkg::TCC_ADDR_W-1:0] reg_addr_i,
   input  wire  logic [7:0]                    reg_wdata_i,
   input  wire  logic                          reg_wr_i,
   input  wire  logic                          reg_rd_i,
   output logic       [7:0]                    reg_rdata_o,
   // external timer clock pin
   input  wire  logic                          ext_timer_clock_pin_i,
   output logic                                ext_clk_force_input_o,
   // channel pins
   input  wire  logic                          channel0_pin_i,
   output logic                                channel0_pin_o,
   output logic                                channel0_pin_oe_o,
   input  wire  logic                          channel1_pin_i,
   output logic                                channel1_pin_o,
   output logic                                channel1_pin_oe_o,
   // interrupt requests
   output logic                                overflow_irq_o,
   output logic       [1:0]                    channel_irq_o
);
   import tcc_pkg::*;

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      logic [15:0]            cnt;
      logic [TCC_PRES_W-1:0]  pres;
      logic [15:0]            modv;
      logic [7:0]             mod_hi_tmp;
      logic                   mod_blk;
      logic                   overflow_flag;
      logic                   tof_arm;
      logic                   overflow_irq_enable;
      logic                   stop;
      logic [2:0]             ps;
      logic [7:0]             cnt_lo_buf;
      logic                   cnt_latched;
      logic [1:0][7:0]        chsc;
      logic [1:0]             ch_arm;
      logic [1:0][15:0]       val;
      logic [1:0][7:0]        val_hi_tmp;
      logic [1:0]             cmp_blk;
      logic [1:0]             cap_blk;
      logic [1:0]             max_eff;
      logic [1:0]             pin_out;
      logic [1:0]             pin_oe;
      logic                   act_sel;
      logic                   last_wr;
      logic                   ext_s1;
      logic                   ext_s2;
      logic                   ext_s3;
      logic [1:0]             pin_s1;
      logic [1:0]             pin_s2;
      logic [1:0]             pin_s3;
      logic [7:0]             rdata;
      logic                   irq_ovf;
      logic [1:0]             irq_ch;
      logic                   ext_in;
   } tcc_state_t;

   tcc_state_t s_q;
   tcc_state_t s_d;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // divider terminal mask: all-ones low bits mark a prescaled tick
   function automatic logic [TCC_PRES_W-1:0] pres_mask(
      input logic [2:0] sel
   );
      logic [TCC_PRES_W:0] one_hot;
      one_hot = (TCC_PRES_W+1)'(1) << sel;
      return TCC_PRES_W'(one_hot - (TCC_PRES_W+1)'(1));
   endfunction

   // offset of a channel register relative to channel 0
   function automatic logic [3:0] ch_ofs(
      input logic [3:0] base,
      input int         ch
   );
      return 4'(base + (ch == 1 ? TCC_CH_STRIDE : 4'h0));
   endfunction

   // --------------------------------------------------------------
   // next-state logic
   // --------------------------------------------------------------
   logic       tick;
   logic       run;
   logic       ovf;
   logic       ovf_set;
   logic       channel0_buffered_select;
   logic [7:0] sc;
   logic [1:0] els;
   logic       en;
   logic       capture;
   logic       compare;
   logic       sel;
   logic       rise;
   logic       fall;
   logic [1:0] cap_ev;
   logic [1:0] cmp_ev;

   always_comb begin
      s_d     = s_q;
      tick    = 1'b0;
      sc      = 8'h00;
      els     = 2'h0;
      en      = 1'b0;
      capture = 1'b0;
      compare = 1'b0;
      sel     = 1'b0;
      rise    = 1'b0;
      fall    = 1'b0;
      cap_ev  = 2'h0;
      cmp_ev  = 2'h0;
      channel0_buffered_select    = s_q.chsc[0][TCC_CH_MSB];

      // synchronisers: first stage feeds only the second
      s_d.ext_s1 = ext_timer_clock_pin_i;
      s_d.ext_s2 = s_q.ext_s1;
      s_d.ext_s3 = s_q.ext_s2;
      s_d.pin_s1 = {channel1_pin_i, channel0_pin_i};
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;

      s_d.pres = s_q.pres + TCC_PRES_W'(1);
      if (s_q.ps == TCC_PS_EXT) begin
         tick = s_q.ext_s2 & ~s_q.ext_s3;
      end else begin
         tick = (s_q.pres & pres_mask(s_q.ps)) == pres_mask(s_q.ps);
      end

      run = tick & ~s_q.stop;
      ovf = run && (s_q.cnt == s_q.modv);
      // pending modulo high write hides overflow
      ovf_set = ovf & ~s_q.mod_blk;
      // wrap to zero on the next timer edge
      if (run) begin
         s_d.cnt = ovf ? TCC_CNT_RST : s_q.cnt + 16'h0001;
      end
      if (ovf_set) begin
         s_d.overflow_flag     = 1'b1;
         s_d.tof_arm = 1'b0;
      end

      if (!channel0_buffered_select) begin
         s_d.act_sel = 1'b0;
         s_d.last_wr = 1'b0;
      end else if (ovf) begin
         s_d.act_sel = s_q.last_wr;
      end

      // per-channel capture, compare and pin logic
      for (int c = 0; c < 2; c++) begin
         sc  = s_q.chsc[c];
         els = sc[TCC_CH_ELSB:TCC_CH_ELSA];
         en  = !(c == 1 && channel0_buffered_select);
         capture = en && !sc[TCC_CH_MSB] && !sc[TCC_CH_MSA] && els != 2'h0;
         compare = en && (sc[TCC_CH_MSB] || sc[TCC_CH_MSA]);
         sel  = (c == 0 && sc[TCC_CH_MSB]) ? s_q.act_sel : c[0];
         rise = s_q.pin_s2[c] & ~s_q.pin_s3[c];
         fall = ~s_q.pin_s2[c] & s_q.pin_s3[c];
         cap_ev[c] = capture && !s_q.stop && !s_q.cap_blk[c]
                     && ((els[0] && rise) || (els[1] && fall));
         // compare held off during value update
         cmp_ev[c] = compare && run && !s_q.cmp_blk[sel]
                     && (s_q.cnt == s_q.val[sel]);
         if (cap_ev[c]) begin
            s_d.val[c] = s_q.cnt;
         end
         if (cap_ev[c] || cmp_ev[c]) begin
            s_d.chsc[c][TCC_CH_FLAG] = 1'b1;
            s_d.ch_arm[c]            = 1'b0;
         end
         // preset level while pin is port-owned
         if (els == 2'h0) begin
            s_d.pin_out[c] = ~sc[TCC_CH_MSA];
         end else if (compare) begin
            if (ovf && sc[TCC_CH_TOV]) begin
               s_d.pin_out[c] = (els == 2'h1) ? ~s_q.pin_out[c] : ~els[0];
            end else if (cmp_ev[c] && !s_q.max_eff[c]) begin
               unique case (els)
                  2'h1:    s_d.pin_out[c] = ~s_q.pin_out[c];
                  2'h2:    s_d.pin_out[c] = 1'b0;
                  default: s_d.pin_out[c] = 1'b1;
               endcase
            end
         end
         if (ovf) begin
            s_d.max_eff[c] = sc[TCC_CH_MAX] & sc[TCC_CH_TOV];
         end
         s_d.pin_oe[c] = compare && els != 2'h0;
      end

      // register writes
      s_d.rdata = 8'h00;
      if (reg_wr_i) begin
         if (reg_addr_i == TCC_OFS_TSC) begin
            if (!reg_wdata_i[TCC_TSC_TOF] && s_q.tof_arm && !ovf_set) begin
               s_d.overflow_flag = 1'b0;
            end
            s_d.tof_arm = 1'b0;
            s_d.overflow_irq_enable    = reg_wdata_i[TCC_TSC_OVERFLOW_IRQ_ENABLE];
            s_d.stop    = reg_wdata_i[TCC_TSC_STOP];
            s_d.ps      = reg_wdata_i[2:0];
            if (reg_wdata_i[TCC_TSC_TRST]) begin
               s_d.cnt         = TCC_CNT_RST;
               s_d.pres        = '0;
               s_d.cnt_latched = 1'b0;
            end
         end
         if (reg_addr_i == TCC_OFS_MOD_HI) begin
            s_d.mod_hi_tmp = reg_wdata_i;
            s_d.mod_blk    = 1'b1;
         end
         if (reg_addr_i == TCC_OFS_MOD_LO) begin
            s_d.modv    = {s_q.mod_hi_tmp, reg_wdata_i};
            s_d.mod_blk = 1'b0;
         end
         for (int c = 0; c < 2; c++) begin
            if (reg_addr_i == ch_ofs(TCC_OFS_CH0_SC, c)
                && !(c == 1 && channel0_buffered_select)) begin
               if (!reg_wdata_i[TCC_CH_FLAG] && s_q.ch_arm[c]
                   && !cap_ev[c] && !cmp_ev[c]) begin
                  s_d.chsc[c][TCC_CH_FLAG] = 1'b0;
               end
               s_d.ch_arm[c]       = 1'b0;
               s_d.chsc[c][6:0]    = reg_wdata_i[6:0];
               // buffered select exists only on channel zero
               if (c == 1) begin
                  s_d.chsc[c][TCC_CH_MSB] = 1'b0;
               end
            end
            if (reg_addr_i == ch_ofs(TCC_OFS_CH0_HI, c)) begin
               s_d.val_hi_tmp[c] = reg_wdata_i;
               s_d.cmp_blk[c]    = 1'b1;
            end
            if (reg_addr_i == ch_ofs(TCC_OFS_CH0_LO, c)) begin
               s_d.val[c]     = {s_q.val_hi_tmp[c], reg_wdata_i};
               s_d.cmp_blk[c] = 1'b0;
               s_d.last_wr    = c[0];
            end
         end
      end

      // register reads and their side effects
      if (reg_rd_i) begin
         if (reg_addr_i == TCC_OFS_TSC) begin
            s_d.rdata = {s_q.overflow_flag, s_q.overflow_irq_enable, s_q.stop, 2'b00, s_q.ps};
            if (s_q.overflow_flag) begin
               s_d.tof_arm = 1'b1;
            end
         end
         if (reg_addr_i == TCC_OFS_CNT_HI) begin
            s_d.rdata = s_q.cnt[15:8];
            if (!s_q.cnt_latched) begin
               s_d.cnt_lo_buf  = s_q.cnt[7:0];
               s_d.cnt_latched = 1'b1;
            end
         end
         if (reg_addr_i == TCC_OFS_CNT_LO) begin
            s_d.rdata = s_q.cnt_latched ? s_q.cnt_lo_buf : s_q.cnt[7:0];
            s_d.cnt_latched = 1'b0;
         end
         if (reg_addr_i == TCC_OFS_MOD_HI) begin
            s_d.rdata = s_q.modv[15:8];
         end
         if (reg_addr_i == TCC_OFS_MOD_LO) begin
            s_d.rdata = s_q.modv[7:0];
         end
         for (int c = 0; c < 2; c++) begin
            sc = s_q.chsc[c];
            if (reg_addr_i == ch_ofs(TCC_OFS_CH0_SC, c)) begin
               s_d.rdata = sc;
               if (sc[TCC_CH_FLAG]) begin
                  s_d.ch_arm[c] = 1'b1;
               end
            end
            if (reg_addr_i == ch_ofs(TCC_OFS_CH0_HI, c)) begin
               s_d.rdata = s_q.val[c][15:8];
               // capture held off until low byte read
               if (!sc[TCC_CH_MSB] && !sc[TCC_CH_MSA]) begin
                  s_d.cap_blk[c] = 1'b1;
               end
            end
            if (reg_addr_i == ch_ofs(TCC_OFS_CH0_LO, c)) begin
               s_d.rdata      = s_q.val[c][7:0];
               s_d.cap_blk[c] = 1'b0;
            end
         end
      end

      // interrupt levels follow flag and enable
      s_d.irq_ovf = s_d.overflow_flag & s_d.overflow_irq_enable;
      for (int c = 0; c < 2; c++) begin
         s_d.irq_ch[c] = s_d.chsc[c][TCC_CH_FLAG] & s_d.chsc[c][TCC_CH_IE];
      end
      // external clock pin forced to input while ps selects TCC_PS_EXT
      s_d.ext_in = (s_d.ps == TCC_PS_EXT);
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   // modulo resets to all ones; counter starts stopped
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q         <= '0;
         s_q.modv    <= TCC_MOD_RST;
         s_q.stop    <= TCC_STOP_RST;
         s_q.pin_out <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   // --------------------------------------------------------------
   // outputs, all straight from the state register
   // --------------------------------------------------------------
   assign reg_rdata_o           = s_q.rdata;
   assign ext_clk_force_input_o = s_q.ext_in;
   assign channel0_pin_o        = s_q.pin_out[0];
   assign channel0_pin_oe_o     = s_q.pin_oe[0];
   assign channel1_pin_o        = s_q.pin_out[1];
   assign channel1_pin_oe_o     = s_q.pin_oe[1];
   assign overflow_irq_o        = s_q.irq_ovf;
   assign channel_irq_o         = s_q.irq_ch;

endmodule // tcc_timer

`default_nettype wire

// ### logic/tcc_pkg.sv
// tcc_pkg: register map, field positions and reset values of the timer
package tcc_pkg;

   // --------------------------------------------------------------
   // register bus geometry and offsets
   // --------------------------------------------------------------
   localparam int          TCC_ADDR_W       = 4;
   localparam logic [3:0]  TCC_OFS_TSC      = 4'h0;
   localparam logic [3:0]  TCC_OFS_CNT_HI   = 4'h1;
   localparam logic [3:0]  TCC_OFS_CNT_LO   = 4'h2;
   localparam logic [3:0]  TCC_OFS_MOD_HI   = 4'h3;
   localparam logic [3:0]  TCC_OFS_MOD_LO   = 4'h4;
   localparam logic [3:0]  TCC_OFS_CH0_SC   = 4'h5;
   localparam logic [3:0]  TCC_OFS_CH0_HI   = 4'h6;
   localparam logic [3:0]  TCC_OFS_CH0_LO   = 4'h7;
   localparam logic [3:0]  TCC_CH_STRIDE    = 4'h3;

   // --------------------------------------------------------------
   // timer status/control fields
   // --------------------------------------------------------------
   localparam int          TCC_TSC_TOF      = 7;
   localparam int          TCC_TSC_OVERFLOW_IRQ_ENABLE     = 6;
   localparam int          TCC_TSC_STOP     = 5;
   localparam int          TCC_TSC_TRST     = 4;
   localparam logic [2:0]  TCC_PS_EXT       = 3'h7;

   // --------------------------------------------------------------
   // channel status/control fields
   // --------------------------------------------------------------
   localparam int          TCC_CH_FLAG      = 7;
   localparam int          TCC_CH_IE        = 6;
   localparam int          TCC_CH_MSB       = 5;
   localparam int          TCC_CH_MSA       = 4;
   localparam int          TCC_CH_ELSB      = 3;
   localparam int          TCC_CH_ELSA      = 2;
   localparam int          TCC_CH_TOV       = 1;
   localparam int          TCC_CH_MAX       = 0;

   // --------------------------------------------------------------
   // widths and reset values
   // --------------------------------------------------------------
   localparam int          TCC_PRES_W       = 6;
   localparam logic [15:0] TCC_MOD_RST      = 16'hffff;
   localparam logic [15:0] TCC_CNT_RST      = 16'h0000;
   localparam logic        TCC_STOP_RST     = 1'b1;

endpackage : tcc_pkg

// ### verification/tcc_timer_asserts.sv
// tcc_timer_asserts: port-level checks of the timer register and pin rules
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_asserts (
   // clock and reset
   input wire logic                            core_clk_i,
   input wire logic                            rst_b_i,
   // register port
   input wire logic [tcc_pkg::TCC_ADDR_W-1:0]  reg_addr_i,
   input wire logic [7:0]                      reg_wdata_i,
   input wire logic                            reg_wr_i,
   input wire logic                            reg_rd_i,
   input wire logic [7:0]                      reg_rdata_o,
   // pins
   input wire logic                            ext_timer_clock_pin_i,
   input wire logic                            ext_clk_force_input_o,
   input wire logic                            channel0_pin_i,
   input wire logic                            channel0_pin_o,
   input wire logic                            channel0_pin_oe_o,
   input wire logic                            channel1_pin_i,
   input wire logic                            channel1_pin_o,
   input wire logic                            channel1_pin_oe_o,
   // interrupt requests
   input wire logic                            overflow_irq_o,
   input wire logic [1:0]                      channel_irq_o
);
   import tcc_pkg::*;
   // ---------------------------------------------------------
   // decoded writes
   // ---------------------------------------------------------
   logic wr_tsc;
   logic wr_ch0;
   assign wr_tsc = reg_wr_i && reg_addr_i == TCC_OFS_TSC;
   assign wr_ch0 = reg_wr_i && reg_addr_i == TCC_OFS_CH0_SC;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // ---------------------------------------------------------
   // properties
   // ---------------------------------------------------------
   read_slot_a: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside its slot");
   trst_reads_a: assert property (
      $past(reg_rd_i && reg_addr_i == TCC_OFS_TSC) |-> !reg_rdata_o[4])
      else $error("counter reset bit read as one");
   ch1_nobuf_a: assert property (
      $past(reg_rd_i && reg_addr_i == TCC_OFS_CH0_SC + TCC_CH_STRIDE)
      |-> !reg_rdata_o[TCC_CH_MSB]) else $error("ch1 buffered bit set");
   ext_in_on_a: assert property (
      wr_tsc && reg_wdata_i[2:0] == TCC_PS_EXT
      |-> ##[1:2] ext_clk_force_input_o) else $error("ext pin not input");
   ext_in_off_a: assert property (
      wr_tsc && reg_wdata_i[2:0] != TCC_PS_EXT
      |-> ##[1:2] !ext_clk_force_input_o) else $error("ext pin forced");
   ovf_irq_off_a: assert property (
      wr_tsc && !reg_wdata_i[TCC_TSC_OVERFLOW_IRQ_ENABLE] |-> ##[1:2] !overflow_irq_o)
      else $error("overflow irq while disabled");
   ch_irq_off_a: assert property (
      wr_ch0 && !reg_wdata_i[TCC_CH_IE] |-> ##[1:2] !channel_irq_o[0])
      else $error("channel irq while disabled");
   preset_lo_a: assert property (
      wr_ch0 && reg_wdata_i[5:2] == 4'b0100
      |-> ##[1:2] (!channel0_pin_oe_o && !channel0_pin_o))
      else $error("preset low level wrong");
   preset_hi_a: assert property (
      wr_ch0 && reg_wdata_i[5:2] == 4'b0000
      |-> ##[1:2] (!channel0_pin_oe_o && channel0_pin_o))
      else $error("preset high level wrong");
endmodule // tcc_timer_asserts
bind tcc_timer tcc_timer_asserts u_asserts (.core_clk_i, .rst_b_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .ext_timer_clock_pin_i, .ext_clk_force_input_o, .channel0_pin_i,
   .channel0_pin_o, .channel0_pin_oe_o, .channel1_pin_i, .channel1_pin_o,
   .channel1_pin_oe_o, .overflow_irq_o, .channel_irq_o);
`default_nettype wire

// ### verification/testbench.sv
// testbench: register-level tests of the two-channel timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tcc_pkg::*;
   logic       core_clk_i = 1'b0, rst_b_i = 1'b0;
   logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, v;
   logic       ext_timer_clock_pin_i = 1'b0, ext_clk_force_input_o;
   logic       channel0_pin_i = 1'b0, channel0_pin_o, channel0_pin_oe_o;
   logic       channel1_pin_i = 1'b0, channel1_pin_o, channel1_pin_oe_o;
   logic       overflow_irq_o;
   logic [1:0] channel_irq_o, els;
   logic [15:0] c;
   int n_fail = 0, comparisons = 0, i, ps;
   tcc_timer dut (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ext_timer_clock_pin_i,
      .ext_clk_force_input_o, .channel0_pin_i, .channel0_pin_o,
      .channel0_pin_oe_o, .channel1_pin_i, .channel1_pin_o,
      .channel1_pin_oe_o, .overflow_irq_o, .channel_irq_o);
   // 20 MHz core clock
   always #25 core_clk_i = ~core_clk_i;
   // ---------------------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1 d = reg_rdata_o; // data stands only in this cycle
   endtask
   task automatic chk(input string n, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic rck(input logic [3:0] a, input logic [7:0] e,
                      input string n);
      rd(a, v);
      chk(n, e, v);
   endtask
   // high byte first so the low byte comes from the latch
   task automatic rcnt(output logic [15:0] x);
      rd(TCC_OFS_CNT_HI, x[15:8]);
      rd(TCC_OFS_CNT_LO, x[7:0]);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // external clock pin: n rising edges, each level held four clocks
   task automatic ext_edges(input int n);
      for (int k = 0; k < 2 * n; k++) begin
         repeat (4) @(posedge core_clk_i);
         ext_timer_clock_pin_i <= ~ext_timer_clock_pin_i;
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   initial begin
      idle(90000);
      n_fail++;
      stop_test;
   end
   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      rck(0, 8'h20, "status reset");
      rck(3, 8'hff, "modulo hi reset");
      rck(4, 8'hff, "modulo lo reset");
      rck(5, 8'h00, "ch0 ctrl reset");
      rcnt(c); chk("counter reset", 16'h0, c);
      wr(4'hf, 8'hff); rck(4'hf, 8'h00, "unmapped");
      $display("test reset done");
      // stop plus counter reset holds at zero
      wr(0, 8'h30); idle(20); rcnt(c); chk("held zero", 16'h0, c);
      // each divider over 256 clocks
      for (ps = 0; ps < 7; ps++) begin
         wr(0, 8'h30); wr(0, 8'(ps)); idle(256); wr(0, 8'h20 | 8'(ps));
         rcnt(c); chk("prescaled", 1, c >= (256 >> ps) && c <= (256 >> ps) + 3);
      end
      wr(0, 8'h30); wr(0, 8'h07); idle(2);
      chk("ext input", 1, ext_clk_force_input_o);
      ext_edges(10);
      idle(6); rcnt(c); chk("ext count", 16'd10, c);
      // later high reads keep the first latched low byte
      rd(TCC_OFS_CNT_HI, v); ext_edges(3); rd(TCC_OFS_CNT_HI, v);
      rck(TCC_OFS_CNT_LO, 8'd10, "latched low");
      rcnt(c); chk("counter moved on", 16'd13, c);
      $display("test prescaler done");
      // overflow at modulo 5, two-step clear
      wr(0, 8'h30); wr(3, 8'h00); wr(4, 8'h05); wr(0, 8'h40);
      for (i = 0; i < 60 && overflow_irq_o !== 1; i++) idle(1);
      chk("ovf irq", 1, overflow_irq_o);
      wr(0, 8'h60); rck(0, 8'he0, "flag kept");
      wr(0, 8'he0); rck(0, 8'he0, "flag one ignored");
      wr(0, 8'h60); idle(2); rck(0, 8'h60, "flag cleared");
      chk("irq dropped", 0, overflow_irq_o);
      wr(0, 8'h30); wr(3, 8'h00); wr(0, 8'h00); idle(40);
      wr(0, 8'h20); rck(0, 8'h20, "ovf suppressed");
      wr(4, 8'h05); wr(0, 8'h00); idle(20); wr(0, 8'h20);
      rck(0, 8'ha0, "ovf again"); wr(0, 8'h20);
      $display("test overflow done");
      // compare actions clear, set, toggle
      wr(5, 8'h10); wr(5, 8'h00);
      wr(3, 8'h00); wr(4, 8'h10); wr(6, 8'h00); wr(7, 8'h08);
      for (i = 0; i < 3; i++) begin
         els = (i == 0) ? 2'd2 : (i == 1) ? 2'd3 : 2'd1;
         wr(0, 8'h30); wr(5, 8'h50 | {4'h0, els, 2'b00}); wr(0, 8'h00);
         for (ps = 0; ps < 60 && channel_irq_o[0] !== 1; ps++) idle(1);
         wr(0, 8'h20);
         chk("cmp drive", 1, channel0_pin_oe_o);
         chk("cmp level", i == 1, channel0_pin_o);
         rck(5, 8'hd0 | {els, 2'b00}, "cmp flag");
         wr(5, 8'h50 | {els, 2'b00}); idle(2);
         chk("cmp irq off", 0, channel_irq_o[0]);
      end
      // full duty: overflow sets the pin, compares no longer clear it
      wr(0, 8'h30); wr(5, 8'h5b); wr(0, 8'h00); idle(60); wr(0, 8'h20);
      idle(2); chk("full duty level", 1, channel0_pin_o);
      $display("test compare done");
      // capture blocked while stopped, then each edge choice
      wr(0, 8'h30); wr(8, 8'h44); channel1_pin_i <= 1'b1; idle(8);
      rck(8, 8'h44, "no capture stopped");
      @(posedge core_clk_i) channel1_pin_i <= 1'b0;
      for (i = 1; i < 4; i++) begin
         els = i[1:0];
         wr(0, 8'h30); wr(8, 8'h40 | {els, 2'b00}); wr(0, 8'h00);
         channel1_pin_i <= 1'b1; idle(8);
         rd(8, v); chk("rise capture", els[0], v[7]);
         wr(8, 8'h40 | {els, 2'b00});
         channel1_pin_i <= 1'b0; idle(8);
         rd(8, v); chk("fall capture", els[1], v[7]);
         wr(8, 8'h40 | {els, 2'b00});
      end
      $display("test capture done");
      // linking locks channel 1 control
      wr(0, 8'h30); wr(8, 8'h58); idle(2);
      chk("ch1 driving", 1, channel1_pin_oe_o);
      wr(5, 8'h28); wr(8, 8'h14);
      rck(8, 8'h58, "ch1 locked");
      chk("ch1 released", 0, channel1_pin_oe_o);
      $display("test buffered done");
      stop_test;
   end
endmodule // testbench
`default_nettype wire
